// ==== uart_lms_defs.vh ====
// register offsets, field positions, reset values and timing counts
`ifndef UART_LMS_DEFS_VH
`define UART_LMS_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_DATA 8'h00
`define OFS_INTERRUPT_ENABLE 8'h04
`define OFS_LINE_FORMAT 8'h0c
`define OFS_MODEM_OUTPUT 8'h10
`define OFS_LINE_STATUS 8'h14
`define OFS_MODEM_INPUT 8'h18
`define OFS_DIVISOR_LOW 8'h20
`define OFS_DIVISOR_HIGH 8'h24
`define OFS_RX_INJECT 8'h28
// ---------------------------------------------------------------
// line format fields
// ---------------------------------------------------------------
`define LF_PARITY_EN 3
`define LF_EVEN 4
`define LF_FORCE 5
`define LF_BREAK 6
`define LF_DIVISOR 7
// ---------------------------------------------------------------
// modem output fields
// ---------------------------------------------------------------
`define MO_TERMINAL 0
`define MO_REQUEST 1
`define MO_GP_ONE 2
`define MO_INT_EN 3
`define MO_LOOP 4
// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define RST_LINE_FORMAT 8'h00
`define RST_MODEM_OUTPUT 8'h00
`define RST_IER 4'h0
`define RST_DIV_LOW 8'h01
`define RST_DIV_HIGH 8'h00
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CHAR_BITS 4'd10
`endif

// ==== sync3.v ====
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 (
   input wire clk_in,
   input wire reset_n_in,
   input wire async_in,
   output reg level_out
);
   reg s1;
   reg s2;
   reg s3;
   // a change counts only once stages two and three agree
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         level_out <= 1'b1;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level_out <= s3;
         end
      end
   end
endmodule // sync3

// ==== uart_line_modem_status_control.v ====
// one uart channel: line format, modem control and line/modem status
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "uart_lms_defs.vh"
module uart_line_modem_status_control (
   // clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // ahb-lite slave
   input wire hsel_in,
   input wire [7:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   // serial line
   output reg tx_out,
   input wire rx_in,
   // modem pins, active low
   output wire terminal_ready_n_out,
   output wire request_to_send_n_out,
   input wire clear_to_send_n_in,
   input wire data_set_ready_n_in,
   input wire ring_indicator_in_n,
   input wire carrier_detect_in_n,
   // interrupt pin, output enable low while driven
   input wire interrupt_drive_select_in,
   output wire irq_out,
   output wire irq_oe_n_out
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg [7:0] line_format_control, modem_output_control, divisor_low_byte, divisor_high_byte;
   reg [3:0] interrupt_enable_reg, modem_delta;
   reg overrun;
   reg [7:0] rd_data;
   // ahb address phase capture
   reg dp_valid, dp_write;
   reg [7:0] dp_addr;
   wire take = hsel_in && hready_in && htrans_in[1];
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready_in) begin
         dp_valid <= take;
         dp_write <= hwrite_in;
         dp_addr <= haddr_in;
      end
   end
   // zero wait states; every access answers okay
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = {24'h000000, rd_data};
   wire wr = dp_valid && dp_write;
   wire divisor_sel = line_format_control[`LF_DIVISOR];
   wire wr_data = wr && (dp_addr == `OFS_DATA) && !divisor_sel;
   wire wr_div_low = wr && (dp_addr == `OFS_DATA) && divisor_sel;
   wire wr_ier = wr && (dp_addr == `OFS_INTERRUPT_ENABLE) && !divisor_sel;
   wire wr_div_high = wr && (dp_addr == `OFS_INTERRUPT_ENABLE) && divisor_sel;
   // read strobes in address phase so data is ready for the data phase
   wire rd_take = take && !hwrite_in;
   wire rd_data_reg = rd_take && (haddr_in == `OFS_DATA) && !divisor_sel;
   wire rd_line = rd_take && (haddr_in == `OFS_LINE_STATUS);
   wire rd_modem = rd_take && (haddr_in == `OFS_MODEM_INPUT);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   wire cts_n_s, dsr_n_s, ri_n_s, cd_n_s, rx_s;
   sync3 u_cts (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .async_in(clear_to_send_n_in), .level_out(cts_n_s));
   sync3 u_dsr (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .async_in(data_set_ready_n_in), .level_out(dsr_n_s));
   sync3 u_ri (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .async_in(ring_indicator_in_n), .level_out(ri_n_s));
   sync3 u_cd (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .async_in(carrier_detect_in_n), .level_out(cd_n_s));
   sync3 u_rx (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .async_in(rx_in), .level_out(rx_s));
   // ---------------------------------------------------------------
   // loopback and modem outputs
   // ---------------------------------------------------------------
   wire loop = modem_output_control[`MO_LOOP];
   // pins idle high in loopback since signals are turned inward
   assign terminal_ready_n_out = loop | ~modem_output_control[`MO_TERMINAL];
   assign request_to_send_n_out = loop | ~modem_output_control[`MO_REQUEST];
   wire loop_general_out_one = ~modem_output_control[`MO_GP_ONE];
   wire loop_general_out_two = ~modem_output_control[`MO_INT_EN];
   wire request_to_send_n_out_int = ~modem_output_control[`MO_REQUEST];
   wire cts_n_i = loop ? request_to_send_n_out_int : cts_n_s;
   wire dsr_n_i = loop ? ~modem_output_control[`MO_TERMINAL] : dsr_n_s;
   wire ri_n_i = loop ? loop_general_out_one : ri_n_s;
   wire cd_n_i = loop ? loop_general_out_two : cd_n_s;
   // ---------------------------------------------------------------
   // baud tick, sixteen per bit
   // ---------------------------------------------------------------
   reg [15:0] baud_cnt;
   wire [15:0] divisor = {divisor_high_byte, divisor_low_byte};
   wire tick = (baud_cnt == 16'h0001) || (divisor == 16'h0000);
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         baud_cnt <= 16'h0001;
      end else if (baud_cnt <= 16'h0001) begin
         baud_cnt <= divisor;
      end else begin
         baud_cnt <= baud_cnt - 16'h0001;
      end
   end
   // ---------------------------------------------------------------
   // parity: fixed eight data bits, one stop bit
   // ---------------------------------------------------------------
   wire par_en = line_format_control[`LF_PARITY_EN];
   wire par_even = line_format_control[`LF_EVEN];
   wire par_force = line_format_control[`LF_FORCE];
   function parity_bit;
      input [7:0] d;
      parity_bit = par_force ? ~par_even : ((^d) ^ ~par_even);
   endfunction
   // ---------------------------------------------------------------
   // transmitter: one holding byte and a shift register
   // ---------------------------------------------------------------
   reg thr_full, tx_busy;
   reg [7:0] transmit_holding_reg;
   reg [10:0] tx_shift;
   reg [3:0] tx_bits, tx_sub;
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         thr_full <= 1'b0;
         transmit_holding_reg <= 8'h00;
         tx_busy <= 1'b0;
         tx_shift <= 11'h7ff;
         tx_bits <= 4'h0;
         tx_sub <= 4'h0;
      end else begin
         if (!tx_busy && thr_full && cts_n_i == 1'b0) begin
            tx_busy <= 1'b1;
            thr_full <= 1'b0;
            tx_shift <= par_en ? {1'b1, parity_bit(transmit_holding_reg), transmit_holding_reg, 1'b0}
                               : {2'b11, transmit_holding_reg, 1'b0};
            tx_bits <= par_en ? 4'd11 : 4'd10;
            tx_sub <= 4'h0;
         end else if (tx_busy && tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hf) begin
               tx_shift <= {1'b1, tx_shift[10:1]};
               tx_bits <= tx_bits - 4'h1;
               if (tx_bits == 4'h1) begin
                  tx_busy <= 1'b0;
               end
            end
         end
         if (wr_data) begin
            thr_full <= 1'b1;
            transmit_holding_reg <= hwdata_in[7:0];
         end
      end
   end
   wire tx_line = line_format_control[`LF_BREAK] ? 1'b0 : tx_shift[0];
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_out <= 1'b1;
      end else begin
         tx_out <= loop ? 1'b1 : tx_line;
      end
   end
   // ---------------------------------------------------------------
   // receiver
   // ---------------------------------------------------------------
   wire rx_line = loop ? tx_line : rx_s;
   reg rx_busy, rx_zero, break_hold, rx_done;
   reg [3:0] rx_sub, rx_bits;
   reg [9:0] rx_shift;
   reg [10:0] rx_word;
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_busy <= 1'b0;
         rx_sub <= 4'h0;
         rx_bits <= 4'h0;
         rx_shift <= 10'h000;
         rx_zero <= 1'b1;
         break_hold <= 1'b0;
         rx_done <= 1'b0;
         rx_word <= 11'h000;
      end else begin
         rx_done <= 1'b0;
         if (rx_line) begin
            break_hold <= 1'b0;
         end
         if (!rx_busy) begin
            if (!rx_line && !break_hold && tick) begin
               rx_busy <= 1'b1;
               rx_sub <= 4'h0;
               rx_bits <= par_en ? 4'd10 : 4'd9;
               rx_zero <= 1'b1;
            end
         end else if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'h7) begin
               rx_shift <= {rx_line, rx_shift[9:1]};
               rx_zero <= rx_zero & ~rx_line;
               rx_bits <= rx_bits - 4'h1;
               // start high at mid-bit: tail of a zero stop bit, not a frame
               if (rx_line && rx_bits == (par_en ? 4'd10 : 4'd9)) begin
                  rx_busy <= 1'b0;
               end
               if (rx_bits == 4'h0) begin
                  rx_busy <= 1'b0;
                  rx_done <= 1'b1;
                  // bits: 0 data, 8 parity error, 9 stop low, 10 break
                  rx_word[7:0] <= par_en ? rx_shift[8:1] : rx_shift[9:2];
                  rx_word[8] <= par_en &&
                     (rx_shift[9] != parity_bit(rx_shift[8:1]));
                  rx_word[9] <= ~rx_line;
                  rx_word[10] <= rx_zero & ~rx_line;
                  break_hold <= rx_zero & ~rx_line;
               end
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // receive fifo with error tags
   // ---------------------------------------------------------------
   reg [10:0] rx_mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW-1:0] wr_ptr, rd_ptr;
   reg [`FIFO_AW:0] count, err_count;
   wire fifo_full = (count == `FIFO_DEPTH);
   wire fifo_empty = (count == 5'd0);
   wire push = rx_done && !fifo_full;
   wire pop = rd_data_reg && !fifo_empty;
   wire [10:0] head = rx_mem[rd_ptr];
   wire push_err = |rx_word[10:8];
   wire pop_err = |head[10:8];
   always @(posedge clk_in) begin
      if (push) begin
         rx_mem[wr_ptr] <= rx_word;
      end
   end
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         count <= 5'd0;
         err_count <= 5'd0;
      end else begin
         wr_ptr <= wr_ptr + {3'h0, push};
         rd_ptr <= rd_ptr + {3'h0, pop};
         count <= count + {4'h0, push} - {4'h0, pop};
         err_count <= err_count + {4'h0, push & push_err} - {4'h0, pop & pop_err};
      end
   end
   // ---------------------------------------------------------------
   // line and modem status flags
   // ---------------------------------------------------------------
   reg [3:0] prev_in;
   wire [3:0] now_in = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
   wire [3:0] delta_set = {now_in[3] ^ prev_in[3], now_in[2] & ~prev_in[2],
                           now_in[1] ^ prev_in[1], now_in[0] ^ prev_in[0]};
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         overrun <= 1'b0;
         modem_delta <= 4'h0;
         prev_in <= 4'hf;
      end else begin
         prev_in <= now_in;
         // set wins over the read clear
         overrun <= (rx_done && fifo_full) | (overrun & ~rd_line);
         modem_delta <= delta_set | (modem_delta & {4{~rd_modem}});
      end
   end
   wire [7:0] line_status = {(err_count != 5'd0),
      !thr_full && !tx_busy,
      !thr_full,
      head[10] & ~fifo_empty, head[9] & ~fifo_empty, head[8] & ~fifo_empty,
      overrun, !fifo_empty};
   wire [7:0] modem_input_status = {~now_in, modem_delta};
   // ---------------------------------------------------------------
   // interrupt pin
   // ---------------------------------------------------------------
   wire line_irq = interrupt_enable_reg[2] && (|line_status[4:1]);
   wire modem_irq = interrupt_enable_reg[3] && (|modem_delta);
   wire rx_irq = interrupt_enable_reg[0] && !fifo_empty;
   wire tx_irq = interrupt_enable_reg[1] && !thr_full;
   assign irq_out = line_irq | modem_irq | rx_irq | tx_irq;
   // select input must be held low by the board in the other bus mode
   assign irq_oe_n_out = ~(modem_output_control[`MO_INT_EN] | interrupt_drive_select_in);
   // ---------------------------------------------------------------
   // register writes and read mux
   // ---------------------------------------------------------------
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         line_format_control <= `RST_LINE_FORMAT;
         modem_output_control <= `RST_MODEM_OUTPUT;
         interrupt_enable_reg <= `RST_IER;
         divisor_low_byte <= `RST_DIV_LOW;
         divisor_high_byte <= `RST_DIV_HIGH;
      end else begin
         if (wr && dp_addr == `OFS_LINE_FORMAT) begin
            line_format_control <= hwdata_in[7:0];
         end
         if (wr && dp_addr == `OFS_MODEM_OUTPUT) begin
            modem_output_control <= {3'h0, hwdata_in[4:0]};
         end
         if (wr_ier) begin
            interrupt_enable_reg <= hwdata_in[3:0];
         end
         if (wr_div_low) begin
            divisor_low_byte <= hwdata_in[7:0];
         end
         if (wr_div_high) begin
            divisor_high_byte <= hwdata_in[7:0];
         end
      end
   end
   reg [7:0] next_rd_data;
   always @* begin
      next_rd_data = 8'h00;
      case (haddr_in)
         `OFS_DATA: next_rd_data = divisor_sel ? divisor_low_byte : head[7:0];
         `OFS_INTERRUPT_ENABLE: next_rd_data = divisor_sel ? divisor_high_byte
                                                           : {4'h0, interrupt_enable_reg};
         `OFS_LINE_FORMAT: next_rd_data = line_format_control;
         `OFS_MODEM_OUTPUT: next_rd_data = modem_output_control;
         `OFS_LINE_STATUS: next_rd_data = line_status;
         `OFS_MODEM_INPUT: next_rd_data = modem_input_status;
         default: next_rd_data = 8'h00;
      endcase
   end
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data <= 8'h00;
      end else begin
         if (rd_take) begin
            rd_data <= next_rd_data;
         end
      end
   end
endmodule // uart_line_modem_status_control

// ==== uart_lms_properties.sv ====
// checker: control shadows decoded from the bus, pin and bus assertions
`timescale 1ns/1ps
`include "uart_lms_defs.vh"
module uart_lms_properties (
   // clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // bus
   input wire hsel_in,
   input wire [7:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire [31:0] hrdata_out,
   input wire hreadyout_out,
   input wire hresp_out,
   // pins
   input wire tx_out,
   input wire terminal_ready_n_out,
   input wire request_to_send_n_out,
   input wire interrupt_drive_select_in,
   input wire irq_out,
   input wire irq_oe_n_out
);
   // ---------------------------------------------------------------
   // shadows follow writes, applied at the end of the data phase
   // ---------------------------------------------------------------
   reg [7:0] lcr_s;
   reg [7:0] mcr_s;
   reg [3:0] ier_s;
   reg pw;
   reg [7:0] pa;
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lcr_s <= 8'h00;
         mcr_s <= 8'h00;
         ier_s <= 4'h0;
         pw <= 1'b0;
         pa <= 8'h00;
      end else if (hready_in) begin
         if (pw && pa == `OFS_LINE_FORMAT) lcr_s <= hwdata_in[7:0];
         if (pw && pa == `OFS_MODEM_OUTPUT) mcr_s <= {3'h0, hwdata_in[4:0]};
         if (pw && pa == `OFS_INTERRUPT_ENABLE && !lcr_s[7]) ier_s <= hwdata_in[3:0];
         pw <= hsel_in && htrans_in[1] && hwrite_in;
         pa <= haddr_in;
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // tx is registered, so one cycle of settling is allowed
   a_break_holds_low: assert property (lcr_s[6] && $past(lcr_s[6]) |-> !tx_out)
      else $error("tx not low during break");
   a_dtr_follows_bit: assert property (!mcr_s[4] |-> terminal_ready_n_out == !mcr_s[0])
      else $error("terminal ready pin wrong");
   a_rts_follows_bit: assert property (!mcr_s[4] |-> request_to_send_n_out == !mcr_s[1])
      else $error("request to send pin wrong");
   a_irq_drive_map: assert property (irq_oe_n_out == !(mcr_s[3] | interrupt_drive_select_in))
      else $error("interrupt drive enable wrong");
   a_loop_pins_high: assert property (mcr_s[4] |-> terminal_ready_n_out && request_to_send_n_out)
      else $error("modem pins active in loopback");
   a_loop_tx_mark: assert property (
      mcr_s[4] && $past(mcr_s[4]) && !lcr_s[6] && !$past(lcr_s[6]) |-> tx_out)
      else $error("tx not idle in loopback");
   a_irq_needs_enable: assert property (ier_s == 4'h0 |-> !irq_out)
      else $error("interrupt without enable");
   a_bus_okay_zero: assert property (hreadyout_out && !hresp_out && hrdata_out[31:8] == 24'h0)
      else $error("bus response wrong");
   c_break: cover property ($rose(lcr_s[6]) ##2 !tx_out);
   c_loop: cover property ($rose(mcr_s[4]));
   c_irq: cover property ($rose(irq_out));
endmodule // uart_lms_properties

// ==== serial_far_end.sv ====
// remote serial device model: modem pins and a serial sender
`timescale 1ns/1ps
module serial_far_end (
   // clock
   input wire clk_in,
   // serial and modem lines, active low modem pins
   output reg rx_line_out,
   output reg cts_n_out,
   output reg dsr_n_out,
   output reg ri_n_out,
   output reg cd_n_out
);
   // idle at mark, modem lines inactive
   initial begin
      rx_line_out = 1'b1;
      {cts_n_out, dsr_n_out, ri_n_out, cd_n_out} = 4'hf;
   end
   // order: clear-to-send, set-ready, ring, carrier
   task set_pins(input [3:0] p);
      {cts_n_out, dsr_n_out, ri_n_out, cd_n_out} <= p;
   endtask
   // one bit is 16 clocks at divisor 1
   task bit_out(input v);
      begin
         rx_line_out <= v;
         repeat (16) @(posedge clk_in);
      end
   endtask
   // start, data lsb first, optional parity, stop, one idle bit
   task send(input [7:0] d, input pe, input pb, input sb);
      integer i;
      begin
         bit_out(1'b0);
         for (i = 0; i < 8; i = i + 1) bit_out(d[i]);
         if (pe) bit_out(pb);
         bit_out(sb);
         bit_out(1'b1);
      end
   endtask
   // line low for two frames, then mark
   task brk;
      begin
         repeat (22) bit_out(1'b0);
         bit_out(1'b1);
      end
   endtask
endmodule // serial_far_end

// ==== uart_line_modem_status_control_tb.sv ====
// testbench for the uart line, modem and status block
`timescale 1ns/1ps
`include "uart_lms_defs.vh"
module uart_line_modem_status_control_tb;
   reg clk_in = 1'b0;
   reg reset_n_in = 1'b0;
   reg hsel = 1'b0;
   reg [7:0] haddr = 8'h00;
   reg [1:0] htrans = 2'b00;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg sel = 1'b0;
   wire [31:0] hrdata;
   wire hrdy, hresp, tx, rx, dtr_n, rts_n, cts_n, dsr_n, ri_n, cd_n, irq, oe_n;
   integer n_fail = 0;
   integer cmp_count = 0;
   integer i, k;
   reg [7:0] q;
   reg [9:0] b;
   always #12.5 clk_in = ~clk_in;
   uart_line_modem_status_control uart_line_modem_status_control_i (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .tx_out(tx), .rx_in(rx),
      .terminal_ready_n_out(dtr_n), .request_to_send_n_out(rts_n),
      .clear_to_send_n_in(cts_n), .data_set_ready_n_in(dsr_n), .ring_indicator_in_n(ri_n),
      .carrier_detect_in_n(cd_n), .interrupt_drive_select_in(sel), .irq_out(irq),
      .irq_oe_n_out(oe_n));
   serial_far_end serial_far_end_i (.clk_in(clk_in), .rx_line_out(rx), .cts_n_out(cts_n),
      .dsr_n_out(dsr_n), .ri_n_out(ri_n), .cd_n_out(cd_n));
   // ---------------------------------------------------------------
   // bus tasks and compare
   // ---------------------------------------------------------------
   task close_out;
      begin
         if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task ck(input [8*6:1] nm, input [7:0] e, input [7:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // bounded wait for hready at a rising edge
   task wrdy;
      integer n;
      begin
         n = 0;
         @(posedge clk_in);
         while (hrdy !== 1'b1) begin
            n = n + 1;
            if (n > 50) begin
               n_fail = n_fail + 1;
               close_out;
            end
            @(posedge clk_in);
         end
      end
   endtask
   task xf(input w, input [7:0] a, input [7:0] d, output [7:0] r);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         wrdy;
         htrans <= 2'b00;
         hwdata <= {24'h0, d};
         wrdy;
         r = hrdata[7:0];
      end
   endtask
   // one more edge so a written control has reached the pins before a check
   task wr(input [7:0] a, input [7:0] d);
      begin
         xf(1'b1, a, d, q);
         @(posedge clk_in);
      end
   endtask
   task rd(input [7:0] a);
      xf(1'b0, a, 8'h00, q);
   endtask
   // capture data, parity and stop bit in mid-bit
   task txcap;
      begin
         k = 0;
         while (tx !== 1'b0 && k < 3000) begin
            k = k + 1;
            @(posedge clk_in);
         end
         if (k >= 3000) n_fail = n_fail + 1;
         repeat (8) @(posedge clk_in);
         for (i = 0; i < 10; i = i + 1) begin
            repeat (16) @(posedge clk_in);
            b[i] = tx;
         end
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      rd(`OFS_LINE_FORMAT); ck("lcr", 8'h00, q);
      rd(`OFS_MODEM_OUTPUT); ck("mcr", 8'h00, q);
      rd(`OFS_LINE_STATUS); ck("lsr", 8'h60, q);
      rd(`OFS_MODEM_INPUT); ck("msr", 8'h00, q);
      rd(8'h3c); ck("unmap", 8'h00, q);
      wr(`OFS_MODEM_OUTPUT, 8'h01); ck("dtr", 8'h00, dtr_n); ck("rts", 8'h01, rts_n);
      wr(`OFS_MODEM_OUTPUT, 8'h02); ck("dtr", 8'h01, dtr_n); ck("rts", 8'h00, rts_n);
      for (k = 0; k < 4; k = k + 1) begin
         sel <= k[1];
         wr(`OFS_MODEM_OUTPUT, {4'h0, k[0], 3'h0});
         ck("oe", {7'h0, ~(k[0] | k[1])}, oe_n);
      end
      sel <= 1'b0;
      wr(`OFS_MODEM_OUTPUT, 8'h1a);
      repeat (8) @(posedge clk_in);
      rd(`OFS_MODEM_INPUT); ck("msrlp", 8'h90, q & 8'hf0);
      ck("txlp", 8'h01, tx);
      wr(`OFS_MODEM_OUTPUT, 8'h00);
      repeat (8) @(posedge clk_in);
      rd(`OFS_MODEM_INPUT);
      wr(`OFS_LINE_FORMAT, 8'h40); repeat (2) @(posedge clk_in); ck("brk", 8'h00, tx);
      wr(`OFS_LINE_FORMAT, 8'h00); repeat (2) @(posedge clk_in); ck("brk", 8'h01, tx);
      wr(`OFS_LINE_FORMAT, 8'h80); rd(`OFS_DATA); ck("dll", `RST_DIV_LOW, q);
      wr(`OFS_DIVISOR_HIGH, 8'h00); wr(`OFS_LINE_FORMAT, 8'h00);
      wr(`OFS_INTERRUPT_ENABLE, 8'h00);
      for (k = 0; k < 4; k = k + 1) begin
         wr(`OFS_LINE_FORMAT, {2'h0, k[1:0], 4'h8});
         serial_far_end_i.send(8'h35, 1'b1, ~k[0], 1'b1);
         rd(`OFS_LINE_STATUS); ck("par", 8'h01, q & 8'h0d);
         rd(`OFS_DATA); ck("rxd", 8'h35, q);
         serial_far_end_i.send(8'h35, 1'b1, k[0], 1'b1);
         rd(`OFS_LINE_STATUS); ck("perr", 8'h85, q & 8'h8d);
         rd(`OFS_DATA); rd(`OFS_LINE_STATUS); ck("clr", 8'h00, q & 8'h85);
      end
      wr(`OFS_LINE_FORMAT, 8'h00);
      serial_far_end_i.send(8'h5a, 1'b0, 1'b0, 1'b0);
      rd(`OFS_LINE_STATUS); ck("ferr", 8'h09, q & 8'h0d);
      rd(`OFS_DATA);
      serial_far_end_i.brk;
      rd(`OFS_LINE_STATUS); ck("rbrk", 8'h11, q & 8'h11);
      rd(`OFS_DATA); rd(`OFS_LINE_STATUS); ck("onebrk", 8'h00, q & 8'h01);
      for (k = 0; k < 17; k = k + 1) serial_far_end_i.send(k[7:0], 1'b0, 1'b0, 1'b1);
      rd(`OFS_LINE_STATUS); ck("ovr", 8'h03, q & 8'h03);
      rd(`OFS_LINE_STATUS); ck("ovrclr", 8'h00, q & 8'h02);
      for (k = 0; k < 16; k = k + 1) begin
         rd(`OFS_DATA); ck("fifo", k[7:0], q);
      end
      rd(`OFS_LINE_STATUS); ck("empty", 8'h00, q & 8'h01);
      wr(`OFS_LINE_FORMAT, 8'h18); wr(`OFS_DATA, 8'ha1);
      repeat (300) @(posedge clk_in);
      ck("halt", 8'h01, tx); rd(`OFS_LINE_STATUS); ck("busy", 8'h00, q & 8'h40);
      serial_far_end_i.set_pins(4'h7);
      txcap; ck("txd", 8'ha1, b[7:0]); ck("txpar", 8'h03, {6'h0, b[9:8]});
      k = 0;
      q = 8'h00;
      while (q[6] !== 1'b1 && k < 40) begin
         k = k + 1;
         rd(`OFS_LINE_STATUS);
      end
      ck("idle", 8'h60, q & 8'h60);
      rd(`OFS_MODEM_INPUT); ck("dcts", 8'h11, q);
      serial_far_end_i.set_pins(4'h3); repeat (8) @(posedge clk_in);
      rd(`OFS_MODEM_INPUT); ck("ddsr", 8'h32, q);
      serial_far_end_i.set_pins(4'h5); repeat (8) @(posedge clk_in);
      rd(`OFS_MODEM_INPUT); ck("rifall", 8'h52, q);
      serial_far_end_i.set_pins(4'h6); repeat (8) @(posedge clk_in);
      rd(`OFS_MODEM_INPUT); ck("ririse", 8'h9c, q);
      wr(`OFS_INTERRUPT_ENABLE, 8'h08);
      serial_far_end_i.set_pins(4'he); repeat (8) @(posedge clk_in);
      ck("irq", 8'h01, irq);
      rd(`OFS_MODEM_INPUT); ck("msr", 8'h81, q); @(posedge clk_in); ck("irqclr", 8'h00, irq);
      close_out;
   end
endmodule // uart_line_modem_status_control_tb
bind uart_line_modem_status_control uart_lms_properties uart_lms_properties_i (.clk_in,
   .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
   .hrdata_out, .hreadyout_out, .hresp_out, .tx_out, .terminal_ready_n_out,
   .request_to_send_n_out, .interrupt_drive_select_in, .irq_out, .irq_oe_n_out);
